//--- bench/tec8_pin_src.sv
module tec8_pin_src (
    // Clock and command
    input  wire logic       mclk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] n_i,
    input  wire logic [7:0] half_i,
    // Pin and state
    output logic            pin_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left_q = 8'h00;
    logic [7:0] cnt_q = 8'h00;
    initial pin_o = 1'b0;
    initial busy_o = 1'b0;
    // Toggle the pin n times, half cycles apart
    always @(posedge mclk_i) begin
        if (go_i && !busy_o) begin
            left_q <= n_i;
            cnt_q <= half_i;
            busy_o <= (n_i != 8'h00);
        end else if (busy_o && cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (busy_o) begin
            pin_o <= ~pin_o;
            cnt_q <= half_i;
            left_q <= left_q - 8'h01;
            busy_o <= (left_q != 8'h01);
        end
    end
endmodule : tec8_pin_src

//--- bench/tec8_timer_sva.sv
module tec8_timer_chk (
    // Clock and reset
    input wire logic        mclk_i,
    input wire logic        arst_n_i,
    // Bus and interrupt
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        timer_irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // Request taken, and one aimed at no register
    sequence s_take;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_bad;
        s_take ##0 (paddr_i > 8'h10 || paddr_i[1:0] != 2'h0);
    endsequence
    AST_ANSWER: assert property (s_take |=> pready_o)
        else $error("answer late");
    AST_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    AST_CAUSE: assert property (pready_o |-> $past(psel_i && penable_i))
        else $error("ready without request");
    AST_ERR_RDY: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    AST_UNMAPPED: assert property (s_bad |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access accepted");
    AST_MAPPED: assert property (s_take ##0 (paddr_i <= 8'h10 &&
        paddr_i[1:0] == 2'h0) |=> !pslverr_o)
        else $error("mapped access refused");
    AST_UPPER: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_IRQ_FALL: assert property ($fell(timer_irq_o) |->
        $past(psel_i && pwrite_i) || $past(psel_i && pwrite_i, 2))
        else $error("request dropped without write");
endmodule : tec8_timer_chk

bind tec8_timer tec8_timer_chk u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .timer_irq_o(timer_irq_o));

//--- bench/tec8_timer_test.sv
module tec8_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        slow_xtal_tick_i = 1'b0;
    logic        go = 1'b0;
    logic [7:0]  n_tg = 8'h00;
    logic [7:0]  half = 8'h01;
    logic [31:0] prdata_o, rd, hold;
    logic        pready_o, pslverr_o, pin, busy, ptp_tick_o, timer_irq_o;
    logic        err;
    logic [31:0] seed = 32'h7AFC;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          lc = 0;
    int          t1, k, c, p, n;
    always #20 mclk_i = ~mclk_i;
    // Cycle count and a crystal tick every fifth cycle
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        lc <= (lc == 4) ? 0 : lc + 1;
        slow_xtal_tick_i <= (lc == 0);
    end
    tec8_timer dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .slow_xtal_tick_i(slow_xtal_tick_i),
        .ext_count_pin_i(pin), .ptp_tick_o(ptp_tick_o),
        .timer_irq_o(timer_irq_o));
    tec8_pin_src u_src (.mclk_i(mclk_i), .go_i(go), .n_i(n_tg),
        .half_i(half), .pin_o(pin), .busy_o(busy));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= 32'(d);
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wait_irq();
        do @(posedge mclk_i); while (timer_irq_o !== 1'b1);
    endtask : wait_irq
    task automatic clr();
        apb(1'b1, tec8_pkg::ADDR_STATUS, 1);
        @(posedge mclk_i);
    endtask : clr
    task automatic src(input int tg, input int h);
        n_tg <= 8'(tg);
        half <= 8'(h);
        go <= 1'b1;
        @(posedge mclk_i);
        go <= 1'b0;
        do @(posedge mclk_i); while (busy === 1'b1);
        repeat (5) @(posedge mclk_i);
    endtask : src
    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, tec8_pkg::ADDR_CONTROL, 0);
        chk(rd, 32'h08);
        apb(1'b0, 8'h20, 0);
        chk(32'(err), 32'h1);
        p = 32'(rnd() & 32'hFF);
        apb(1'b1, tec8_pkg::ADDR_PRELOAD, p);
        apb(1'b0, tec8_pkg::ADDR_COUNT, 0);
        chk(rd, 32'(p));
        apb(1'b1, tec8_pkg::ADDR_SYSCTL, 1);
        for (k = 0; k < 8; k++) begin
            p = 32'h0F0 | 32'(rnd() & 32'h7);
            apb(1'b1, tec8_pkg::ADDR_CONTROL, 32'h90 | k);
            apb(1'b1, tec8_pkg::ADDR_PRELOAD, p);
            wait_irq();
            clr();
            if (k == 3) fork src(60, 2); join_none
            wait_irq();
            clr();
            wait_irq();
            t1 = cyc;
            clr();
            wait_irq();
            chk(32'(cyc - t1), 32'((256 - p) << k));
        end
        apb(1'b1, tec8_pkg::ADDR_SYSCTL, 0);
        repeat (300) @(posedge mclk_i);
        chk(32'(timer_irq_o), 32'h0);
        apb(1'b0, tec8_pkg::ADDR_STATUS, 0);
        chk(32'(rd[0]), 32'h1);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, tec8_pkg::ADDR_CONTROL, 32'hB0);
            apb(1'b1, tec8_pkg::ADDR_SYSCTL, 2 * k);
            c = 0;
            repeat (50) @(posedge mclk_i) c += 32'(ptp_tick_o === 1'b1);
            chk(32'(c), k ? 32'd50 : 32'd10);
        end
        apb(1'b1, tec8_pkg::ADDR_SYSCTL, 0);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, tec8_pkg::ADDR_CONTROL, 32'h08);
            apb(1'b1, tec8_pkg::ADDR_PRELOAD, 0);
            apb(1'b1, tec8_pkg::ADDR_CONTROL, 32'h57 | (k << 3));
            n = 32'(1 + (rnd() & 32'h1F));
            src(2 * n, 32'(1 + (rnd() & 32'h3)));
            apb(1'b0, tec8_pkg::ADDR_COUNT, 0);
            chk(rd, 32'(n));
        end
        for (k = 0; k < 2; k++) begin
            src(1, 1);
            apb(1'b1, tec8_pkg::ADDR_CONTROL, 32'h08);
            apb(1'b1, tec8_pkg::ADDR_PRELOAD, 0);
            apb(1'b1, tec8_pkg::ADDR_CONTROL, 32'hD0 | (k << 3));
            n = 32'(20 + (rnd() & 32'h1F));
            src(2, n);
            apb(1'b0, tec8_pkg::ADDR_COUNT, 0);
            hold = rd;
            chk(hold, 32'(n));
            src(2, 3);
            apb(1'b0, tec8_pkg::ADDR_COUNT, 0);
            chk(rd, hold);
        end
        // Disabled and no-mode settings must leave the count alone
        apb(1'b1, tec8_pkg::ADDR_CONTROL, 32'h08);
        apb(1'b1, tec8_pkg::ADDR_PRELOAD, 32'h33);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, tec8_pkg::ADDR_CONTROL, k ? 32'h10 : 32'h40);
            src(4, 1);
            apb(1'b0, tec8_pkg::ADDR_COUNT, 0);
            chk(rd, 32'h33);
        end
        conclude();
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge mclk_i);
        n_mismatch++;
        conclude();
    end
endmodule : tec8_timer_test

//--- hdl/tec8_pin_sync.sv
// Two-flop synchroniser with registered edge compare on the stage-two output
module tec8_pin_sync (
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 arst_n_i,
    // Pin and edges
    input  wire logic                 pin_i,
    output tec8_pkg::tec8_edges_t     edges_o,
    output logic                      level_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } tec8_sync_t;

    tec8_sync_t st_q;
    tec8_sync_t st_d;

    // Shift the pin through the chain
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    // State register
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Edges compare stage two against stage three only
    assign edges_o.rise = st_q.s2 & ~st_q.s3;
    assign edges_o.fall = ~st_q.s2 & st_q.s3;
    assign level_o      = st_q.s2;

endmodule : tec8_pin_sync

//--- hdl/tec8_pkg.sv
package tec8_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] ADDR_COUNT   = 8'h00;
    localparam logic [7:0] ADDR_PRELOAD = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_SYSCTL  = 8'h10;

    // Control field positions
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_CSEL    = 5;
    localparam int CTL_EN      = 4;
    localparam int CTL_EDGE    = 3;
    localparam int CTL_PSC_HI  = 2;
    localparam int CTL_PSC_LO  = 0;

    // System control field positions
    localparam int SYS_IRQ_EN  = 0;
    localparam int SYS_PWM_EN  = 1;

    // Status field positions
    localparam int STA_OVF     = 0;
    localparam int STA_ACTIVE  = 1;
    localparam int STA_DONE    = 2;

    // Reset values and count limit
    localparam logic [7:0] CONTROL_RST = 8'h08;
    localparam logic [7:0] ZERO8       = 8'h00;
    localparam logic [7:0] MAX_COUNT   = 8'hFF;

    // Operating modes
    typedef enum logic [1:0] {
        TEC8_MODE_NONE  = 2'b00,
        TEC8_MODE_EVENT = 2'b01,
        TEC8_MODE_TIMER = 2'b10,
        TEC8_MODE_PULSE = 2'b11
    } tec8_mode_t;

    // Pulse capture phases
    typedef enum logic [1:0] {
        TEC8_CAP_WAIT = 2'b00,
        TEC8_CAP_RUN  = 2'b01,
        TEC8_CAP_DONE = 2'b10
    } tec8_cap_t;

    // Pin edge detector bundle
    typedef struct packed {
        logic rise;
        logic fall;
    } tec8_edges_t;

endpackage : tec8_pkg

//--- hdl/tec8_timer.sv
// Function
// - Counter is eight bits wide and only counts up.
// - Mode 00 none, 01 event count, 10 interval timer, 11 pulse capture.
// - Timer and pulse capture modes count internal prescaled clock, not pin.
// - Clock select 0 picks system clock, 1 picks low-frequency crystal.
// - PWM enabled forces system clock regardless of clock select.
// - Prescale code 000 to 111 divides by 1 up to 128.
// - Event mode counts pin rising edges, or falling with edge select set.
// - Pulse capture: edge select 0 starts falling, stops rising; 1 inverse.
// - Enable bit zero stops counting; one lets it advance.
// - Count passing FFH flags overflow and raises interrupt request.
// - Overflow reloads counter from preload and keeps counting.
// - Preload write while disabled also loads the counter at once.
// - Preload write while running updates preload only until overflow.
// - Reading the count register returns the live counter value.
// - Selected prescaler input clock is shared with time-base and PWM.
// - Pin-clocked counting ignores prescaler; each qualified edge counts.
// - Overflow request reaches processor only when interrupt enable set.
//
// Implementation choices: register access over APB and the register offsets.
module tec8_timer (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Clock sources and pin
    input  wire logic        slow_xtal_tick_i,
    input  wire logic        ext_count_pin_i,
    // Shared clock and interrupt
    output logic             ptp_tick_o,
    output logic             timer_irq_o
);

    typedef struct packed {
        logic [7:0]          count;
        logic [7:0]          preload;
        logic [7:0]          control;
        logic [1:0]          sysctl;
        logic                ovf;
        tec8_pkg::tec8_cap_t cap;
        logic [6:0]          psc;
        logic                ptp;
        logic                irq;
        logic [31:0]         rdata;
        logic                ready;
        logic                slverr;
        logic [2:0]          cfg_prev;
    } tec8_state_t;

    tec8_state_t st_q;
    tec8_state_t st_d;

    tec8_pkg::tec8_edges_t pin_edges;
    logic                  pin_level;

    // Pin synchroniser and edge detect
    tec8_pin_sync u_sync (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .pin_i    (ext_count_pin_i),
        .edges_o  (pin_edges),
        .level_o  (pin_level)
    );

    // Prescaler tap: divide by two to the power of the code
    function automatic logic psc_tap(input logic [6:0] cnt,
                                     input logic [2:0] code);
        logic [6:0] mask;
        mask = 7'h7F >> (3'h7 - code);
        return (cnt & mask) == mask;
    endfunction : psc_tap

    // Register decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction : hit

    logic                 acc;
    logic                 wr;
    logic                 src_tick;
    logic                 int_tick;
    logic                 inc;
    logic                 start_e;
    logic                 stop_e;
    logic                 en;
    logic [2:0]           code;
    logic [7:0]           wbyte;
    tec8_pkg::tec8_mode_t mode;

    always_comb begin
        st_d     = st_q;
        acc      = psel_i & penable_i & ~st_q.ready;
        wr       = acc & pwrite_i;
        wbyte    = pwdata_i[7:0];
        mode     = tec8_pkg::tec8_mode_t'(
                   st_q.control[tec8_pkg::CTL_MODE_HI:
                                tec8_pkg::CTL_MODE_LO]);
        en       = st_q.control[tec8_pkg::CTL_EN];
        code     = st_q.control[tec8_pkg::CTL_PSC_HI:tec8_pkg::CTL_PSC_LO];

        // Prescaler input select, PWM override
        if (st_q.sysctl[tec8_pkg::SYS_PWM_EN]) begin
            src_tick = 1'b1;
        end else if (st_q.control[tec8_pkg::CTL_CSEL]) begin
            src_tick = slow_xtal_tick_i;
        end else begin
            src_tick = 1'b1;
        end
        st_d.ptp = src_tick;

        // Prescaler divide
        int_tick = src_tick & psc_tap(st_q.psc, code);
        if (src_tick) begin
            st_d.psc = st_q.psc + 7'h01;
        end

        // Pulse capture edges by edge select
        start_e = st_q.control[tec8_pkg::CTL_EDGE] ? pin_edges.rise
                                                   : pin_edges.fall;
        stop_e  = st_q.control[tec8_pkg::CTL_EDGE] ? pin_edges.fall
                                                   : pin_edges.rise;

        // Increment qualification per mode
        inc = 1'b0;
        unique case (mode)
            tec8_pkg::TEC8_MODE_NONE: begin
                inc = 1'b0;
            end
            tec8_pkg::TEC8_MODE_EVENT: begin
                inc = st_q.control[tec8_pkg::CTL_EDGE] ? pin_edges.fall
                                                       : pin_edges.rise;
            end
            tec8_pkg::TEC8_MODE_TIMER: begin
                inc = int_tick;
            end
            tec8_pkg::TEC8_MODE_PULSE: begin
                inc = int_tick & (st_q.cap == tec8_pkg::TEC8_CAP_RUN);
            end
        endcase
        inc = inc & en;

        // Capture phase tracking
        if (!en || mode != tec8_pkg::TEC8_MODE_PULSE
            || st_q.cfg_prev != {en, mode}) begin
            st_d.cap = tec8_pkg::TEC8_CAP_WAIT;
        end else begin
            unique case (st_q.cap)
                tec8_pkg::TEC8_CAP_WAIT: begin
                    if (start_e) begin
                        st_d.cap = tec8_pkg::TEC8_CAP_RUN;
                    end
                end
                tec8_pkg::TEC8_CAP_RUN: begin
                    if (stop_e) begin
                        st_d.cap = tec8_pkg::TEC8_CAP_DONE;
                    end
                end
                tec8_pkg::TEC8_CAP_DONE: begin
                    st_d.cap = tec8_pkg::TEC8_CAP_DONE;
                end
                default: begin
                    st_d.cap = tec8_pkg::TEC8_CAP_WAIT;
                end
            endcase
        end
        st_d.cfg_prev = {en, mode};

        // Counting with overflow reload
        if (inc) begin
            if (st_q.count == tec8_pkg::MAX_COUNT) begin
                st_d.count = st_q.preload;
                st_d.ovf   = 1'b1;
            end else begin
                st_d.count = st_q.count + 8'h01;
            end
        end

        // APB writes and reads
        st_d.ready  = acc;
        st_d.slverr = 1'b0;
        st_d.rdata  = '0;
        if (wr) begin
            if (hit(paddr_i, tec8_pkg::ADDR_PRELOAD)) begin
                st_d.preload = wbyte;
                if (!en) begin
                    st_d.count = wbyte;
                end
            end else if (hit(paddr_i, tec8_pkg::ADDR_CONTROL)) begin
                st_d.control = wbyte;
            end else if (hit(paddr_i, tec8_pkg::ADDR_SYSCTL)) begin
                st_d.sysctl = wbyte[1:0];
            end else if (hit(paddr_i, tec8_pkg::ADDR_STATUS)) begin
                // Write one clears overflow; a new overflow wins
                if (wbyte[tec8_pkg::STA_OVF] && !(inc &&
                    st_q.count == tec8_pkg::MAX_COUNT)) begin
                    st_d.ovf = 1'b0;
                end
            end else if (!hit(paddr_i, tec8_pkg::ADDR_COUNT)) begin
                st_d.slverr = 1'b1;
            end
        end else if (acc) begin
            if (hit(paddr_i, tec8_pkg::ADDR_COUNT)) begin
                st_d.rdata[7:0] = st_q.count;
            end else if (hit(paddr_i, tec8_pkg::ADDR_PRELOAD)) begin
                st_d.rdata[7:0] = st_q.preload;
            end else if (hit(paddr_i, tec8_pkg::ADDR_CONTROL)) begin
                st_d.rdata[7:0] = st_q.control;
            end else if (hit(paddr_i, tec8_pkg::ADDR_SYSCTL)) begin
                st_d.rdata[1:0] = st_q.sysctl;
            end else if (hit(paddr_i, tec8_pkg::ADDR_STATUS)) begin
                st_d.rdata[tec8_pkg::STA_OVF]    = st_q.ovf;
                st_d.rdata[tec8_pkg::STA_ACTIVE] =
                    st_q.cap == tec8_pkg::TEC8_CAP_RUN;
                st_d.rdata[tec8_pkg::STA_DONE]   =
                    st_q.cap == tec8_pkg::TEC8_CAP_DONE;
            end else begin
                st_d.slverr = 1'b1;
            end
        end

        // Masked interrupt request
        st_d.irq = st_d.ovf & st_d.sysctl[tec8_pkg::SYS_IRQ_EN];
    end

    // State register; preload resets to zero as a defined value
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q         <= '0;
            st_q.control <= tec8_pkg::CONTROL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs from flops
    assign prdata_o    = st_q.rdata;
    assign pready_o    = st_q.ready;
    assign pslverr_o   = st_q.slverr;
    assign ptp_tick_o  = st_q.ptp;
    assign timer_irq_o = st_q.irq;

    logic unused_level;
    assign unused_level = pin_level;

endmodule : tec8_timer
